// ### inc/sp_map.svh
`ifndef SP_MAP_SVH
`define SP_MAP_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SP_OFF_BUF 32'h0000_0000
`define SP_OFF_CTRL 32'h0000_0004
`define SP_OFF_STAT 32'h0000_0008

// ----------------------------------------
// control register fields
// ----------------------------------------
`define SP_CTRL_MODE_LO 0
`define SP_CTRL_OPTION 2
`define SP_CTRL_RX_EN 3
`define SP_CTRL_RX_DONE 4
`define SP_CTRL_TX_DONE 5
`define SP_CTRL_NINTH 6
`define SP_CTRL_RATE_DBL 7
`define SP_CTRL_RESET 8'h00
`define SP_MODE_SYNC 2'h0
`define SP_MODE_ASYNC 2'h1

// ----------------------------------------
// shift timing, in hclk cycles
// ----------------------------------------
`define SP_M0_FAST_LAST 4'h3
`define SP_M0_FAST_FALL 4'h1
`define SP_M0_FAST_RISE 4'h3
`define SP_M0_SLOW_LAST 4'hb
`define SP_M0_SLOW_FALL 4'h3
`define SP_M0_SLOW_RISE 4'h9

// ----------------------------------------
// asynchronous frame
// ----------------------------------------
`define SP_DIV_LAST 4'hf
`define SP_VOTE_A 4'h7
`define SP_VOTE_B 4'h8
`define SP_VOTE_C 4'h9
`define SP_STOP_IDX 4'h9
`define SP_DATA_LAST 4'h8

`endif

// ### inc/sp_pkg.sv
package sp_pkg;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {
		SP_M0_IDLE = 2'b00,
		SP_M0_TX = 2'b01,
		SP_M0_RX = 2'b11
	} sp_m0_state_t;

	typedef enum logic [1:0] {
		SP_RX_IDLE = 2'b00,
		SP_RX_START = 2'b01,
		SP_RX_DATA = 2'b11,
		SP_RX_STOP = 2'b10
	} sp_rx_state_t;

	typedef struct packed {
		logic rate_double;
		logic rx_ninth_bit;
		logic tx_done_flag;
		logic rx_done_flag;
		logic rx_enable;
		logic mode_option_bit;
		logic [1:0] mode;
	} sp_ctrl_t;

endpackage : sp_pkg

// ### design/sp_serial_port.sv
// The implementer's own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`include "sp_map.svh"
module sp_serial_port (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic t1_overflow,
	input wire logic rxd_in,
	output logic rxd_out,
	output logic rxd_oe,
	output logic txd
);

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	sp_pkg::sp_ctrl_t ctrl_reg;
	sp_pkg::sp_m0_state_t m0_state_reg;
	sp_pkg::sp_rx_state_t rx_state_reg;
	logic [7:0] rx_buf_reg;
	logic [31:0] ph_addr_reg;
	logic ph_write_reg;
	logic ph_valid_reg;
	logic rx_meta_reg;
	logic rx_sync_reg;
	logic [3:0] m0_ph_reg;
	logic [2:0] m0_bit_reg;
	logic [7:0] m0_shift_reg;
	logic m0_take_reg;
	logic m0_last_reg;
	logic half_reg;
	logic [3:0] tx_div_reg;
	logic tx_pend_reg;
	logic tx_run_reg;
	logic [3:0] tx_bit_reg;
	logic [7:0] tx_shift_reg;
	logic [3:0] rx_div_reg;
	logic rx_prev_reg;
	logic vote_a_reg;
	logic vote_b_reg;
	logic [3:0] rx_bit_reg;
	logic [7:0] rx_shift_reg;
	logic buf_wr;
	logic ctrl_wr;
	logic mode0;
	logic mode1;
	logic m0_end;
	logic m0_fall;
	logic m0_rise;
	logic m0_tx_done;
	logic m0_rx_done;
	logic tick;
	logic tx_roll;
	logic m1_stop_out;
	logic vote_now;
	logic vote;
	logic m1_rx_load;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// sel 0: last phase of a bit, 1: falling edge, 2: rising edge
	function automatic logic [3:0] m0_point(input logic fast, input logic [1:0] sel);
		logic [3:0] r;
		r = fast ? `SP_M0_FAST_LAST : `SP_M0_SLOW_LAST;
		if (sel == 2'h1) begin
			r = fast ? `SP_M0_FAST_FALL : `SP_M0_SLOW_FALL;
		end else if (sel == 2'h2) begin
			r = fast ? `SP_M0_FAST_RISE : `SP_M0_SLOW_RISE;
		end
		return r;
	endfunction : m0_point

	function automatic logic majority(input logic a, input logic b, input logic c);
		return (a & b) | (a & c) | (b & c);
	endfunction : majority

	function automatic logic addr_is(input logic [31:0] a, input logic [31:0] off);
		return a[7:2] == off[7:2] && a[31:8] == 24'h00_0000;
	endfunction : addr_is

	// ----------------------------------------
	// ahb-lite slave
	// ----------------------------------------
	// zero wait states, so hready and hresp never move after reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			ph_valid_reg <= 1'b0;
			ph_write_reg <= 1'b0;
			ph_addr_reg <= 32'h0000_0000;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (hready) begin
				ph_valid_reg <= hsel && htrans[1];
				ph_write_reg <= hwrite;
				ph_addr_reg <= haddr;
			end
		end
	end

	assign buf_wr = ph_valid_reg && ph_write_reg && addr_is(ph_addr_reg, `SP_OFF_BUF);
	assign ctrl_wr = ph_valid_reg && ph_write_reg && addr_is(ph_addr_reg, `SP_OFF_CTRL);

	// read data is picked in the address phase so hrdata comes from a flop
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			if (addr_is(haddr, `SP_OFF_BUF)) begin
				hrdata <= {24'h00_0000, rx_buf_reg};
			end else if (addr_is(haddr, `SP_OFF_CTRL)) begin
				hrdata <= {24'h00_0000, ctrl_reg};
			end else if (addr_is(haddr, `SP_OFF_STAT)) begin
				hrdata <= {30'h0000_0000, rx_state_reg != sp_pkg::SP_RX_IDLE
					|| m0_state_reg == sp_pkg::SP_M0_RX,
					tx_pend_reg || tx_run_reg || m0_state_reg == sp_pkg::SP_M0_TX};
			end else begin
				hrdata <= 32'h0000_0000;
			end
		end
	end

	// ----------------------------------------
	// control register and flags
	// ----------------------------------------
	assign mode0 = ctrl_reg.mode == `SP_MODE_SYNC;
	assign mode1 = ctrl_reg.mode == `SP_MODE_ASYNC;

	// hardware set wins over a software clear in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_reg <= `SP_CTRL_RESET;
		end else begin
			if (ctrl_wr) begin
				ctrl_reg.mode <= hwdata[`SP_CTRL_MODE_LO +: 2];
				ctrl_reg.mode_option_bit <= hwdata[`SP_CTRL_OPTION];
				ctrl_reg.rx_enable <= hwdata[`SP_CTRL_RX_EN];
				ctrl_reg.rate_double <= hwdata[`SP_CTRL_RATE_DBL];
			end
			if (m0_tx_done || m1_stop_out) begin
				ctrl_reg.tx_done_flag <= 1'b1;
			end else if (ctrl_wr && hwdata[`SP_CTRL_TX_DONE]) begin
				ctrl_reg.tx_done_flag <= 1'b0;
			end
			if (m0_rx_done || m1_rx_load) begin
				ctrl_reg.rx_done_flag <= 1'b1;
			end else if (ctrl_wr && hwdata[`SP_CTRL_RX_DONE]) begin
				ctrl_reg.rx_done_flag <= 1'b0;
			end
			if (m1_rx_load) begin
				ctrl_reg.rx_ninth_bit <= vote;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_buf_reg <= 8'h00;
		end else if (m0_rx_done) begin
			rx_buf_reg <= {rx_sync_reg, m0_shift_reg[7:1]};
		end else if (m1_rx_load) begin
			rx_buf_reg <= rx_shift_reg;
		end
	end

	// ----------------------------------------
	// rxd pin synchroniser
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_meta_reg <= 1'b1;
			rx_sync_reg <= 1'b1;
		end else begin
			rx_meta_reg <= rxd_in;
			rx_sync_reg <= rx_meta_reg;
		end
	end

	// ----------------------------------------
	// mode 0 shift engine
	// ----------------------------------------
	assign m0_end = m0_ph_reg == m0_point(ctrl_reg.mode_option_bit, 2'h0);
	assign m0_fall = m0_ph_reg == m0_point(ctrl_reg.mode_option_bit, 2'h1);
	assign m0_rise = m0_ph_reg == m0_point(ctrl_reg.mode_option_bit, 2'h2);
	assign m0_tx_done = m0_state_reg == sp_pkg::SP_M0_TX && m0_end && m0_bit_reg == 3'h7;
	assign m0_rx_done = m0_take_reg && m0_last_reg;

	// the synchroniser costs two clocks and the fast rate leaves only two
	// between fall and rise, so the bit seen at the rise is taken one clock later
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			m0_state_reg <= sp_pkg::SP_M0_IDLE;
			m0_ph_reg <= 4'h0;
			m0_bit_reg <= 3'h0;
			m0_shift_reg <= 8'h00;
			m0_take_reg <= 1'b0;
			m0_last_reg <= 1'b0;
		end else begin
			m0_take_reg <= m0_state_reg == sp_pkg::SP_M0_RX && m0_rise;
			m0_last_reg <= m0_bit_reg == 3'h7;
			case (m0_state_reg)
			sp_pkg::SP_M0_IDLE: begin
				m0_ph_reg <= 4'h0;
				m0_bit_reg <= 3'h0;
				if (mode0 && buf_wr) begin
					m0_state_reg <= sp_pkg::SP_M0_TX;
					m0_shift_reg <= hwdata[7:0];
				end else if (mode0 && ctrl_reg.rx_enable && !ctrl_reg.rx_done_flag) begin
					m0_state_reg <= sp_pkg::SP_M0_RX;
				end
			end
			sp_pkg::SP_M0_TX: begin
				m0_ph_reg <= m0_end ? 4'h0 : m0_ph_reg + 4'h1;
				if (m0_end) begin
					m0_shift_reg <= {1'b0, m0_shift_reg[7:1]};
					m0_bit_reg <= m0_bit_reg + 3'h1;
					if (m0_bit_reg == 3'h7) begin
						m0_state_reg <= sp_pkg::SP_M0_IDLE;
					end
				end
			end
			sp_pkg::SP_M0_RX: begin
				m0_ph_reg <= m0_end ? 4'h0 : m0_ph_reg + 4'h1;
				if (m0_take_reg) begin
					m0_shift_reg <= {rx_sync_reg, m0_shift_reg[7:1]};
				end
				if (m0_rx_done) begin
					m0_state_reg <= sp_pkg::SP_M0_IDLE;
				end else if (m0_end) begin
					m0_bit_reg <= m0_bit_reg + 3'h1;
				end
			end
			default: begin
				m0_state_reg <= sp_pkg::SP_M0_IDLE;
			end
			endcase
		end
	end

	// data goes out at phase 0, one or three clocks ahead of the fall
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rxd_out <= 1'b1;
			rxd_oe <= 1'b0;
		end else if (m0_state_reg == sp_pkg::SP_M0_TX) begin
			rxd_oe <= 1'b1;
			if (m0_ph_reg == 4'h0) begin
				rxd_out <= m0_shift_reg[0];
			end
		end else begin
			rxd_oe <= 1'b0;
			rxd_out <= 1'b1;
		end
	end

	// ----------------------------------------
	// mode 1 bit clock
	// ----------------------------------------
	assign tick = t1_overflow && (ctrl_reg.rate_double || half_reg);
	assign tx_roll = tick && tx_div_reg == `SP_DIV_LAST;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			half_reg <= 1'b0;
			tx_div_reg <= 4'h0;
		end else begin
			if (t1_overflow) begin
				half_reg <= !half_reg;
			end
			if (tick) begin
				tx_div_reg <= tx_div_reg + 4'h1;
			end
		end
	end

	// ----------------------------------------
	// mode 1 transmitter
	// ----------------------------------------
	assign m1_stop_out = tx_roll && tx_run_reg && tx_bit_reg == `SP_STOP_IDX;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_pend_reg <= 1'b0;
			tx_run_reg <= 1'b0;
			tx_bit_reg <= 4'h0;
			tx_shift_reg <= 8'h00;
		end else begin
			if (mode1 && buf_wr) begin
				tx_pend_reg <= 1'b1;
				tx_shift_reg <= hwdata[7:0];
			end else if (tx_roll && tx_pend_reg) begin
				tx_pend_reg <= 1'b0;
				tx_run_reg <= 1'b1;
				tx_bit_reg <= 4'h1;
			end else if (tx_roll && tx_run_reg) begin
				tx_bit_reg <= tx_bit_reg + 4'h1;
				if (tx_bit_reg != `SP_STOP_IDX) begin
					tx_shift_reg <= {1'b1, tx_shift_reg[7:1]};
				end else begin
					tx_run_reg <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------
	// transmit line
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			txd <= 1'b1;
		end else if (mode0) begin
			if (m0_state_reg == sp_pkg::SP_M0_IDLE) begin
				txd <= 1'b1;
			end else if (m0_fall) begin
				txd <= 1'b0;
			end else if (m0_rise) begin
				txd <= 1'b1;
			end
		end else if (tx_roll && tx_pend_reg && !(mode1 && buf_wr)) begin
			txd <= 1'b0;
		end else if (tx_roll && tx_run_reg) begin
			txd <= tx_bit_reg == `SP_STOP_IDX ? 1'b1 : tx_shift_reg[0];
		end
	end

	// ----------------------------------------
	// mode 1 receiver
	// ----------------------------------------
	assign vote_now = tick && rx_state_reg != sp_pkg::SP_RX_IDLE && rx_div_reg == `SP_VOTE_C;
	assign vote = majority(vote_a_reg, vote_b_reg, rx_sync_reg);
	// a refused frame is dropped whole, the buffer keeps the older byte
	assign m1_rx_load = vote_now && rx_state_reg == sp_pkg::SP_RX_STOP
		&& !ctrl_reg.rx_done_flag && (!ctrl_reg.mode_option_bit || vote);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_state_reg <= sp_pkg::SP_RX_IDLE;
			rx_div_reg <= 4'h0;
			rx_prev_reg <= 1'b1;
			vote_a_reg <= 1'b1;
			vote_b_reg <= 1'b1;
			rx_bit_reg <= 4'h0;
			rx_shift_reg <= 8'h00;
		end else if (!mode1) begin
			rx_state_reg <= sp_pkg::SP_RX_IDLE;
			rx_prev_reg <= 1'b1;
		end else if (tick) begin
			rx_prev_reg <= rx_sync_reg;
			rx_div_reg <= rx_div_reg + 4'h1;
			if (rx_div_reg == `SP_VOTE_A) begin
				vote_a_reg <= rx_sync_reg;
			end
			if (rx_div_reg == `SP_VOTE_B) begin
				vote_b_reg <= rx_sync_reg;
			end
			case (rx_state_reg)
			sp_pkg::SP_RX_IDLE: begin
				if (ctrl_reg.rx_enable && rx_prev_reg && !rx_sync_reg) begin
					rx_state_reg <= sp_pkg::SP_RX_START;
					rx_div_reg <= 4'h0;
				end
			end
			sp_pkg::SP_RX_START: begin
				if (vote_now) begin
					rx_bit_reg <= 4'h0;
					rx_state_reg <= vote ? sp_pkg::SP_RX_IDLE : sp_pkg::SP_RX_DATA;
				end
			end
			sp_pkg::SP_RX_DATA: begin
				if (vote_now) begin
					rx_shift_reg <= {vote, rx_shift_reg[7:1]};
					rx_bit_reg <= rx_bit_reg + 4'h1;
					if (rx_bit_reg + 4'h1 == `SP_DATA_LAST) begin
						rx_state_reg <= sp_pkg::SP_RX_STOP;
					end
				end
			end
			sp_pkg::SP_RX_STOP: begin
				if (vote_now) begin
					rx_state_reg <= sp_pkg::SP_RX_IDLE;
				end
			end
			default: begin
				rx_state_reg <= sp_pkg::SP_RX_IDLE;
			end
			endcase
		end
	end

endmodule : sp_serial_port

// ### verification/sp_serial_port_asserts.sv
`timescale 1ns/1ps
module sp_serial_port_asserts (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic rxd_out,
	input wire logic rxd_oe,
	input wire logic txd
);
	logic txd_q;
	logic [3:0] nfall;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// ------
	// shift clock falls within one driven frame
	// ------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			txd_q <= 1'b1;
			nfall <= 4'h0;
		end else begin
			txd_q <= txd;
			if (!rxd_oe)
				nfall <= 4'h0;
			else if (txd_q && !txd)
				nfall <= nfall + 4'h1;
		end
	end
	bus_okay_a: assert property (hreadyout && !hresp) else $error("bus not ready");
	upper_zero_a: assert property (hrdata[31:8] == 24'h00_0000) else $error("upper bits");
	rdata_hold_a: assert property (!(hsel && hready && htrans[1] && !hwrite) |=>
		$stable(hrdata)) else $error("read data moved");
	clk_start_a: assert property ($rose(rxd_oe) |-> ##[1:12] $fell(txd))
		else $error("no shift clock");
	data_lead_a: assert property ($changed(rxd_out) && rxd_oe && $past(rxd_oe) |->
		##1 $fell(txd) or ##3 $fell(txd)) else $error("data lead wrong");
	clk_low_a: assert property ($fell(txd) && rxd_oe |=>
		!txd ##1 (txd or (!txd [*4] ##1 txd))) else $error("clock low time");
	frame_bits_a: assert property ($fell(rxd_oe) |-> nfall == 4'h8)
		else $error("bit count");
	clk_idle_a: assert property ($fell(rxd_oe) |-> txd) else $error("clock not high");
endmodule : sp_serial_port_asserts
bind sp_serial_port sp_serial_port_asserts u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
	.hresp(hresp), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd));

// ### verification/sp_far_end.sv
`timescale 1ns/1ps
module sp_far_end (
	input wire logic txd,
	input wire logic rxd_oe,
	input wire logic rxd_w,
	output logic rxd_far
);
	logic [7:0] got;
	logic [7:0] pres;
	logic act;
	int n;
	initial begin
		rxd_far = 1'b1;
		got = 8'h00;
		pres = 8'h00;
		act = 1'b0;
		n = 8;
	end
	// ------
	// shift register: samples on the falling clock edge, avoiding a race with frame end
	// ------
	always @(negedge txd) begin
		if (rxd_oe) begin
			got = {rxd_w, got[7:1]};
		end else if (act && n < 8) begin
			rxd_far = pres[n];
			n++;
		end
	end
	// released after the last rise; the far end drives the line high again
	always @(posedge txd) begin
		if (act && n == 8) begin
			act = 1'b0;
			rxd_far = 1'b1;
		end
	end
	task m0_load(input logic [7:0] b);
		pres = b;
		n = 0;
		act = 1'b1;
	endtask : m0_load
	// start clear of the bus clock edge so the synchroniser never races the pin
	task m1_low(input int t);
		#2;
		rxd_far = 1'b0;
		#(t);
		rxd_far = 1'b1;
	endtask : m1_low
	// one asynchronous frame at 2000 ns per bit
	task m1_send(input logic [7:0] b, input logic s);
		#2;
		rxd_far = 1'b0;
		#2000;
		for (int i = 0; i < 8; i++) begin
			rxd_far = b[i];
			#2000;
		end
		rxd_far = s;
		#2000;
		rxd_far = 1'b1;
	endtask : m1_send
endmodule : sp_far_end

// ### verification/sp_serial_port_tb.sv
`timescale 1ns/1ps
`include "sp_map.svh"
module sp_serial_port_tb;
	logic hclk, hresetn, hsel, hwrite, t1_overflow, lk, lk_q;
	logic [31:0] haddr, hwdata, hrdata, d;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic hreadyout, hresp, rxd_out, rxd_oe, txd, rxd_far, rxd_w;
	logic [9:0] fr;
	int n_errors, n_tests, oe_cyc, i, r;
	realtime t0;
	assign rxd_w = rxd_oe ? rxd_out : rxd_far;
	sp_serial_port u_sp_serial_port (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .t1_overflow(t1_overflow),
		.rxd_in(rxd_w), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd));
	sp_far_end u_sp_far_end (.txd(txd), .rxd_oe(rxd_oe), .rxd_w(rxd_w), .rxd_far(rxd_far));
	always #5 hclk = ~hclk;
	// link clock offset so its edges never meet bus clock edges
	initial begin
		lk = 1'b0;
		#3;
		forever #62.5 lk = ~lk;
	end
	always @(posedge hclk) begin
		lk_q <= lk;
		t1_overflow <= lk && !lk_q;
		if (rxd_oe === 1'b1)
			oe_cyc++;
	end
	task tally_and_finish;
		$display("checks %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish
	task chk(input logic [31:0] s, input logic [31:0] e, input string w);
		n_tests++;
		if (s !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", w, e, s);
			n_errors++;
		end
	endtask : chk
	task tmo;
		$display("wait ran out");
		n_errors++;
		tally_and_finish;
	endtask : tmo
	task rdy;
		int j;
		for (j = 0; j < 20 && hreadyout !== 1'b1; j++)
			@(posedge hclk);
		if (j == 20)
			tmo;
	endtask : rdy
	task bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= w;
		@(posedge hclk);
		rdy;
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= wd;
		@(posedge hclk);
		rdy;
		d = hrdata;
	endtask : bus
	task wait_bit(input int b, input logic v);
		int j;
		for (j = 0; j < 3000; j++) begin
			bus(1'b0, `SP_OFF_CTRL, 32'h0000_0000);
			if (d[b] === v)
				break;
		end
		if (j == 3000)
			tmo;
	endtask : wait_bit
	task wait_txd(input logic v, output int c);
		for (c = 0; c < 1000 && txd !== v; c++)
			@(posedge hclk);
		if (c == 1000)
			tmo;
	endtask : wait_txd
	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		t1_overflow = 1'b0;
		lk_q = 1'b0;
		n_errors = 0;
		n_tests = 0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		chk(32'(txd), 32'h0000_0001, "txd idle");
		bus(1'b0, `SP_OFF_CTRL, 32'h0000_0000);
		chk(d, 32'h0000_0000, "ctrl reset");
		bus(1'b0, 32'h0000_000C, 32'h0000_0000);
		chk(d, 32'h0000_0000, "unmapped");
		// ------
		// mode 0 transmit at both rates
		// ------
		for (r = 0; r < 2; r++) begin
			bus(1'b1, `SP_OFF_CTRL, 32'(r) << 2);
			oe_cyc = 0;
			bus(1'b1, `SP_OFF_BUF, r ? 32'h0000_00A5 : 32'h0000_003C);
			wait_bit(5, 1'b1);
			chk(32'(u_sp_far_end.got), r ? 32'h0000_00A5 : 32'h0000_003C, "m0 tx");
			chk(32'(oe_cyc >= (r ? 30 : 94) && oe_cyc <= (r ? 34 : 98)), 32'h1, "m0 rate");
			bus(1'b1, `SP_OFF_CTRL, 32'h0000_0020 | (32'(r) << 2));
		end
		bus(1'b0, `SP_OFF_BUF, 32'h0000_0000);
		chk(d, 32'h0000_0000, "rx apart");
		// mode 0 receive, then halted while the flag stands
		for (r = 0; r < 2; r++) begin
			u_sp_far_end.m0_load(r ? 8'h5B : 8'hA6);
			bus(1'b1, `SP_OFF_CTRL, 32'h0000_0018 | (32'(r) << 2));
			wait_bit(4, 1'b1);
			bus(1'b0, `SP_OFF_BUF, 32'h0000_0000);
			chk(d, r ? 32'h0000_005B : 32'h0000_00A6, "m0 rx");
		end
		repeat (200) @(posedge hclk);
		bus(1'b0, `SP_OFF_STAT, 32'h0000_0000);
		chk(d, 32'h0000_0000, "m0 halted");
		bus(1'b1, `SP_OFF_CTRL, 32'h0000_0010);
		// ------
		// mode 1 transmit, bits taken at their middles
		// ------
		bus(1'b1, `SP_OFF_CTRL, 32'h0000_0081);
		bus(1'b1, `SP_OFF_BUF, 32'h0000_0069);
		wait_txd(1'b0, i);
		t0 = $realtime;
		fr = {1'b1, 8'h69, 1'b0};
		for (r = 0; r < 10; r++) begin
			#(t0 + 1000.0 + 2000.0 * r - $realtime);
			chk(32'(txd), 32'(fr[r]), "m1 tx bit");
			if (r > 7) begin
				bus(1'b0, `SP_OFF_CTRL, 32'h0000_0000);
				chk(32'(d[5]), 32'(r == 9), "m1 tx flag");
			end
		end
		// undoubled rate doubles the start bit
		bus(1'b1, `SP_OFF_CTRL, 32'h0000_0021);
		bus(1'b1, `SP_OFF_BUF, 32'h0000_0069);
		wait_txd(1'b0, i);
		wait_txd(1'b1, i);
		chk(32'(i >= 396 && i <= 404), 32'h0000_0001, "m1 slow");
		wait_bit(5, 1'b1);
		// ------
		// mode 1 receive
		// ------
		bus(1'b1, `SP_OFF_CTRL, 32'h0000_0081);
		u_sp_far_end.m1_send(8'h77, 1'b1);
		bus(1'b0, `SP_OFF_CTRL, 32'h0000_0000);
		chk(32'(d[4]), 32'h0000_0000, "rx disabled");
		bus(1'b1, `SP_OFF_CTRL, 32'h0000_00A9);
		u_sp_far_end.m1_low(300);
		#3000;
		bus(1'b0, `SP_OFF_STAT, 32'h0000_0000);
		chk(32'(d[1]), 32'h0000_0000, "false start");
		u_sp_far_end.m1_send(8'hC3, 1'b1);
		wait_bit(4, 1'b1);
		chk(32'(d[6]), 32'h0000_0001, "ninth bit");
		bus(1'b0, `SP_OFF_BUF, 32'h0000_0000);
		chk(d, 32'h0000_00C3, "m1 rx");
		u_sp_far_end.m1_send(8'h11, 1'b1);
		#2000;
		bus(1'b0, `SP_OFF_BUF, 32'h0000_0000);
		chk(d, 32'h0000_00C3, "frame lost");
		bus(1'b1, `SP_OFF_CTRL, 32'h0000_009D);
		u_sp_far_end.m1_send(8'h22, 1'b0);
		#2000;
		bus(1'b0, `SP_OFF_CTRL, 32'h0000_0000);
		chk(32'(d[4]), 32'h0000_0000, "bad stop");
		u_sp_far_end.m1_send(8'h5A, 1'b1);
		wait_bit(4, 1'b1);
		bus(1'b0, `SP_OFF_BUF, 32'h0000_0000);
		chk(d, 32'h0000_005A, "resumed");
		tally_and_finish;
	end
endmodule : sp_serial_port_tb
